/* dv/phyxc_ext_ctrl_checker.sv */
// Port-level assertions for the extended control register block
`timescale 1ns/1ps
`default_nettype none
module phyxc_ext_ctrl_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sw_reset,
  input wire logic mdio_oe,
  input wire logic [4:0] led_addr_pins,
  input wire logic speed_100_pin,
  input wire logic tx_err,
  input wire logic [4:0] std_symbol,
  input wire logic tx_serial_bit,
  input wire logic [4:0] tx_symbol,
  input wire logic tx_line_bit,
  input wire logic [4:0] phy_addr,
  input wire logic override_protected_bit_wr_en,
  input wire logic scr_lock_loss,
  input wire logic scr_bypass,
  input wire logic nrzi_sel
);
  // ----------------------------------------
  // Properties, all in the one clock domain
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rst; $rose(resetn) |-> nrzi_sel && !override_protected_bit_wr_en && !scr_lock_loss; endproperty
  property p_swrst; sw_reset |=> nrzi_sel && !override_protected_bit_wr_en; endproperty
  property p_keep; sw_reset |=> $stable(phy_addr); endproperty
  property p_cap; $rose(resetn) |-> ##8 phy_addr == led_addr_pins; endproperty
  property p_slow; !speed_100_pin [*8] |=> scr_bypass && !scr_lock_loss; endproperty
  property p_std; !tx_err |=> tx_symbol == $past(std_symbol); endproperty
  property p_nrz; !nrzi_sel |=> tx_line_bit == $past(tx_serial_bit); endproperty
  property p_nrzi; nrzi_sel |=> tx_line_bit == ($past(tx_line_bit) ^ $past(tx_serial_bit)); endproperty
  a_rst: assert property (p_rst) else $error("bad control bits after reset");
  a_swrst: assert property (p_swrst) else $error("bad control bits after soft reset");
  a_keep: assert property (p_keep) else $error("port address moved on soft reset");
  a_cap: assert property (p_cap) else $error("port address not captured");
  a_slow: assert property (p_slow) else $error("scrambler active at low speed");
  a_std: assert property (p_std) else $error("standard symbol not passed");
  a_nrz: assert property (p_nrz) else $error("plain coding wrong");
  a_nrzi: assert property (p_nrzi) else $error("invert-on-one coding wrong");
  // Main scenarios reached
  cover property ($rose(mdio_oe));
  cover property ($fell(override_protected_bit_wr_en));
  cover property (sw_reset);
endmodule
bind phyxc_ext_ctrl phyxc_ext_ctrl_checker chk (.*);
`default_nettype wire

/* dv/phyxc_sme_model.sv */
// Management station model that sends frames on the management pins
`timescale 1ns/1ps
`default_nettype none
module phyxc_sme_model (
  input wire logic clk,
  output logic mdc,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  import phyxc_pkg::*;
  logic drv = 1'b1;
  // Shared data line; pull-up level when released
  assign mdio_i = mdio_oe ? mdio_o : drv;
  // Management clock, low between frames
  logic mdc_r = 1'b0;
  assign mdc = mdc_r;
  // One bit: data set while clock low, read back at the rising edge
  task automatic bit_cyc(input logic b, output logic s);
    drv = b;
    repeat (12) @(negedge clk);
    mdc_r = 1'b1;
    s = mdio_i;
    repeat (12) @(negedge clk);
    mdc_r = 1'b0;
  endtask
  // Whole frame with preamble; on a read the line is released after the address
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--)
    begin
      bit_cyc((op == PHYXC_OP_READ && i < 18) ? 1'b1 : f[i], s);
      rd[i[3:0]] = (i < 16) ? s : rd[i[3:0]];
    end
    drv = 1'b1;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the extended control register
`timescale 1ns/1ps
`default_nettype none
module tb;
  import phyxc_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, sw_reset = 1'b0, speed_100_pin = 1'b1, tx_err = 1'b0, tx_serial_bit = 1'b0;
  logic mdc, mdio_i, mdio_o, mdio_oe, tx_line_bit, override_protected_bit_wr_en, scr_lock_loss, scr_bypass;
  logic nrzi_sel;
  logic [4:0] led_addr_pins = 5'h00, std_symbol = 5'h00, tx_symbol, phy_addr, pa;
  logic [3:0] tx_nibble = 4'h0;
  logic [15:0] rd, m;
  int fail_count = 0, check_count = 0;
  // ----------------------------------
  // Clock, design and station model
  // ----------------------------------
  always #5 clk = ~clk;
  phyxc_ext_ctrl dut (.*);
  phyxc_sme_model sme (.*);
  // Test translation of one transmit nibble
  function automatic logic [4:0] xl(input logic [3:0] n);
    logic [4:0] t[7] = '{5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
    return n < 4'h8 ? {1'b0, n} : (n == 4'h8 ? 5'h00 : t[n - 4'h9]);
  endfunction
  // Expected register word from the control model and the address
  function automatic logic [15:0] ev();
    return (m & 16'h802D) | {5'h00, pa, 6'h00};
  endfunction
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Register access through management frames
  task automatic wr(input logic [15:0] d, input logic [4:0] r);
    sme.xfer(PHYXC_OP_WRITE, pa, r, d, rd);
  endtask
  task automatic rc();
    sme.xfer(PHYXC_OP_READ, pa, PHYXC_REG_EXT_CTRL, 16'h0000, rd);
    chk(rd, ev());
  endtask
  // Hang guard
  initial
  begin
    #600000;
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    void'($urandom(85828));
    pa = 5'($urandom);
    led_addr_pins = pa;
    repeat (6) @(negedge clk);
    resetn = 1;
    repeat (20) @(negedge clk);
    m = 16'h0008;
    rc();
    repeat (4)
    begin
      m = 16'($urandom) & 16'h07ED;
      wr(m, PHYXC_REG_EXT_CTRL);
      rc();
      chk(16'({scr_lock_loss, scr_bypass, nrzi_sel}), 16'({m[5], m[0], m[3]}));
    end
    wr(16'h8000, PHYXC_REG_EXT_CTRL);
    chk(16'(override_protected_bit_wr_en), 16'h0001);
    wr(16'h0000, 5'h00);
    m = 16'h0000;
    chk(16'(override_protected_bit_wr_en), 16'h0000);
    m = 16'h0025;
    wr(m, PHYXC_REG_EXT_CTRL);
    chk(16'({scr_lock_loss, scr_bypass, nrzi_sel}), 16'h0006);
    sw_reset = 1'b1;
    @(negedge clk);
    sw_reset = 1'b0;
    m = 16'h0008;
    sme.xfer(PHYXC_OP_WRITE, ~pa, PHYXC_REG_EXT_CTRL, 16'h0001, rd);
    rc();
    m = 16'h0020;
    wr(m, PHYXC_REG_EXT_CTRL);
    chk(16'({scr_lock_loss, scr_bypass}), 16'h0002);
    speed_100_pin = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'({scr_lock_loss, scr_bypass}), 16'h0001);
    speed_100_pin = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 16'h0008 : 16'h0004;
      wr(m, PHYXC_REG_EXT_CTRL);
      for (int i = 0; i < 48; i++)
      begin
        tx_nibble = i[3:0];
        tx_err = (i < 16) || 1'($urandom);
        std_symbol = 5'($urandom);
        tx_serial_bit = 1'($urandom);
        @(negedge clk);
        chk(16'(tx_symbol), 16'((tx_err && k == 0) ? xl(tx_nibble) : std_symbol));
      end
    end
    pa = ~pa;
    resetn = 0;
    led_addr_pins = pa;
    repeat (6) @(negedge clk);
    resetn = 1;
    repeat (20) @(negedge clk);
    chk(16'(phy_addr), 16'(pa));
    complete_run();
  end
endmodule
`default_nettype wire

/* rtl/phyxc_ext_ctrl.sv */
// Extended control register with its management port slave and transmit test controls
//
// Contract
// - A set override enable clears itself after the next management write to another register of this port, so only that one write may alter protected bits.
// - Reserved bits 14 to 11, 4 and 1 always read as zero.
// - The five-bit port address is taken from the LED pins at hardware reset and shown read-only in bits 10 to 6.
// - A software reset leaves the latched port address alone.
// - The scrambler test bit forces loss of scrambler lock only in 100 Mb/s mode; clear means normal operation.
// - In 100 Mb/s mode the serial transmit stream is plain NRZ when the coding bit is zero and NRZI when it is one.
// - With the invalid-code bit clear the standard translation is used; set, the test translation applies only while transmit error is high.
// - In test translation nibbles 0000 to 0111 become a zero followed by the nibble, and 1000 becomes 00000.
// - In test translation 1001..1111 become 01101, 01100, 10001, 10000, 11001, 11000 and 11111.
// - The scrambler disable bit bypasses both transmit scrambler and receive descrambler; clear keeps both active only in 100 Mb/s mode.
// - Scrambling is applied only in 100 Mb/s operation.
`timescale 1ns/1ps
`default_nettype none
module phyxc_ext_ctrl
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sw_reset,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] led_addr_pins,
  input wire logic speed_100_pin,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_err,
  input wire logic [4:0] std_symbol,
  input wire logic tx_serial_bit,
  output logic [4:0] tx_symbol,
  output logic tx_line_bit,
  output logic [4:0] phy_addr,
  output logic override_protected_bit_wr_en,
  output logic scr_lock_loss,
  output logic scr_bypass,
  output logic nrzi_sel
);
  import phyxc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum {PHYXC_IDLE, PHYXC_START, PHYXC_HDR, PHYXC_TA, PHYXC_DATA} phyxc_fsm_e;

  typedef struct packed {
    logic [2:0] mdc_s;
    logic [2:0] mdio_s;
    logic [2:0] spd_s;
    logic [4:0] led_s0;
    logic [4:0] led_s1;
    logic [4:0] led_s2;
    logic mdc_f;
    logic mdio_f;
    logic spd_f;
    phyxc_fsm_e fsm;
    logic [5:0] pre_cnt;
    logic [4:0] bcnt;
    logic [15:0] sh;
    logic is_rd;
    logic is_wr;
    logic hit;
    logic hit_reg;
    logic mdo;
    logic mdo_oe;
    logic [1:0] cap_cnt;
    logic cap_done;
    logic [4:0] addr;
    logic ovr;
    logic scr_test;
    logic nrzi;
    logic inv_code;
    logic scr_dis;
    logic [4:0] sym;
    logic line;
    logic lock_loss;
    logic bypass;
  } phyxc_state_s;

  phyxc_state_s s_q;
  phyxc_state_s s_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Filtered level: a change counts once the second and third stages agree
  function automatic logic phyxc_filt(input logic [2:0] s, input logic f);
    phyxc_filt = (s[1] == s[2]) ? s[1] : f;
  endfunction

  // Test translation of a transmit nibble
  function automatic logic [4:0] phyxc_inv_map(input logic [3:0] n);
    logic [4:0] r;
    r = 5'h00;
    unique case (n)
      4'h8: r = 5'h00;
      4'h9: r = 5'h0D;
      4'hA: r = 5'h0C;
      4'hB: r = 5'h11;
      4'hC: r = 5'h10;
      4'hD: r = 5'h19;
      4'hE: r = 5'h18;
      4'hF: r = 5'h1F;
      default: r = {1'b0, n};
    endcase
    phyxc_inv_map = r;
  endfunction

  // Register image as read; reserved bits read zero
  function automatic logic [15:0] phyxc_image(input phyxc_state_s s);
    logic [15:0] v;
    v = 16'h0000;
    v[PHYXC_BIT_OVR] = s.ovr;
    v[PHYXC_BIT_ADDR_HI:PHYXC_BIT_ADDR_LO] = s.addr;
    v[PHYXC_BIT_SCR_TEST] = s.scr_test;
    v[PHYXC_BIT_NRZI] = s.nrzi;
    v[PHYXC_BIT_INV_CODE] = s.inv_code;
    v[PHYXC_BIT_SCR_DIS] = s.scr_dis;
    phyxc_image = v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic b;
    rise = 1'b0;
    fall = 1'b0;
    b = 1'b0;
    s_d = s_q;
    // Input synchronisers and filters
    s_d.mdc_s = {s_q.mdc_s[1:0], mdc};
    s_d.mdio_s = {s_q.mdio_s[1:0], mdio_i};
    s_d.spd_s = {s_q.spd_s[1:0], speed_100_pin};
    s_d.led_s0 = led_addr_pins;
    s_d.led_s1 = s_q.led_s0;
    s_d.led_s2 = s_q.led_s1;
    s_d.mdc_f = phyxc_filt(s_q.mdc_s, s_q.mdc_f);
    s_d.mdio_f = phyxc_filt(s_q.mdio_s, s_q.mdio_f);
    s_d.spd_f = phyxc_filt(s_q.spd_s, s_q.spd_f);
    rise = s_d.mdc_f & ~s_q.mdc_f;
    fall = ~s_d.mdc_f & s_q.mdc_f;
    b = s_d.mdio_f;

    // Port address capture once after hardware reset, never on software reset
    if (!s_q.cap_done)
    begin
      if (s_q.cap_cnt != PHYXC_SYNC_FILL)
        s_d.cap_cnt = s_q.cap_cnt + 2'h1;
      else if (s_q.led_s1 == s_q.led_s2)
      begin
        s_d.addr = s_q.led_s2;
        s_d.cap_done = 1'b1;
      end
    end

    // Management frame receive on rising clock
    if (rise)
    begin
      unique case (s_q.fsm)
        PHYXC_IDLE:
        begin
          if (b)
            s_d.pre_cnt = (s_q.pre_cnt == PHYXC_PREAMBLE_LEN) ? s_q.pre_cnt : s_q.pre_cnt + 6'h01;
          else if (s_q.pre_cnt == PHYXC_PREAMBLE_LEN)
            s_d.fsm = PHYXC_START;
          else
            s_d.pre_cnt = 6'h00;
        end
        PHYXC_START:
        begin
          s_d.pre_cnt = 6'h00;
          s_d.bcnt = 5'h00;
          s_d.fsm = b ? PHYXC_HDR : PHYXC_IDLE;
        end
        PHYXC_HDR:
        begin
          s_d.sh = {s_q.sh[14:0], b};
          s_d.bcnt = s_q.bcnt + 5'h01;
          if (s_q.bcnt == PHYXC_HDR_LAST)
          begin
            s_d.is_rd = s_d.sh[11:10] == PHYXC_OP_READ;
            s_d.is_wr = s_d.sh[11:10] == PHYXC_OP_WRITE;
            s_d.hit = s_d.cap_done && (s_d.sh[9:5] == s_d.addr);
            s_d.hit_reg = s_d.sh[4:0] == PHYXC_REG_EXT_CTRL;
            s_d.bcnt = 5'h00;
            s_d.fsm = (s_d.is_rd | s_d.is_wr) ? PHYXC_TA : PHYXC_IDLE;
          end
        end
        PHYXC_TA:
        begin
          s_d.bcnt = s_q.bcnt + 5'h01;
          if (s_q.bcnt == 5'h01)
          begin
            s_d.bcnt = 5'h00;
            s_d.sh = phyxc_image(s_q);
            s_d.fsm = PHYXC_DATA;
          end
        end
        PHYXC_DATA:
        begin
          if (s_q.is_wr)
            s_d.sh = {s_q.sh[14:0], b};
          s_d.bcnt = s_q.bcnt + 5'h01;
          if (s_q.bcnt == PHYXC_DATA_LAST)
          begin
            s_d.fsm = PHYXC_IDLE;
            if (s_q.is_wr && s_q.hit)
            begin
              if (s_q.hit_reg)
              begin
                s_d.ovr = s_d.sh[PHYXC_BIT_OVR];
                s_d.scr_test = s_d.sh[PHYXC_BIT_SCR_TEST];
                s_d.nrzi = s_d.sh[PHYXC_BIT_NRZI];
                s_d.inv_code = s_d.sh[PHYXC_BIT_INV_CODE];
                s_d.scr_dis = s_d.sh[PHYXC_BIT_SCR_DIS];
              end
              else
                s_d.ovr = 1'b0;
            end
          end
        end
      endcase
    end

    // Read data driven on falling clock
    if (fall)
    begin
      if (s_q.fsm == PHYXC_TA && s_q.bcnt == 5'h01 && s_q.is_rd && s_q.hit && s_q.hit_reg)
      begin
        s_d.mdo_oe = 1'b1;
        s_d.mdo = 1'b0;
      end
      else if (s_q.fsm == PHYXC_DATA && s_q.mdo_oe)
      begin
        s_d.mdo = s_q.sh[15];
        s_d.sh = {s_q.sh[14:0], 1'b0};
      end
      else if (s_q.fsm == PHYXC_IDLE)
        s_d.mdo_oe = 1'b0;
    end

    // Software reset restores control bits only
    if (sw_reset)
    begin
      s_d.ovr = PHYXC_RST_OVR;
      s_d.scr_test = PHYXC_RST_SCR_TEST;
      s_d.nrzi = PHYXC_RST_NRZI;
      s_d.inv_code = PHYXC_RST_INV_CODE;
      s_d.scr_dis = PHYXC_RST_SCR_DIS;
    end

    // Transmit path controls
    s_d.sym = (s_q.inv_code && tx_err) ? phyxc_inv_map(tx_nibble) : std_symbol;
    s_d.line = s_q.nrzi ? (s_q.line ^ tx_serial_bit) : tx_serial_bit;
    s_d.lock_loss = s_q.scr_test & s_q.spd_f;
    s_d.bypass = s_q.scr_dis | ~s_q.spd_f;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.fsm <= PHYXC_IDLE;
      s_q.ovr <= PHYXC_RST_OVR;
      s_q.scr_test <= PHYXC_RST_SCR_TEST;
      s_q.nrzi <= PHYXC_RST_NRZI;
      s_q.inv_code <= PHYXC_RST_INV_CODE;
      s_q.scr_dis <= PHYXC_RST_SCR_DIS;
      s_q.bypass <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops
  assign mdio_o = s_q.mdo;
  assign mdio_oe = s_q.mdo_oe;
  assign tx_symbol = s_q.sym;
  assign tx_line_bit = s_q.line;
  assign phy_addr = s_q.addr;
  assign override_protected_bit_wr_en = s_q.ovr;
  assign scr_lock_loss = s_q.lock_loss;
  assign scr_bypass = s_q.bypass;
  assign nrzi_sel = s_q.nrzi;
endmodule
`default_nettype wire

/* rtl/phyxc_pkg.sv */
// Package: extended control register map, field layout, reset values, management frame codes
package phyxc_pkg;
  localparam logic [4:0] PHYXC_REG_EXT_CTRL = 5'h10;
  localparam int PHYXC_BIT_OVR = 15;
  localparam int PHYXC_BIT_ADDR_HI = 10;
  localparam int PHYXC_BIT_ADDR_LO = 6;
  localparam int PHYXC_BIT_SCR_TEST = 5;
  localparam int PHYXC_BIT_NRZI = 3;
  localparam int PHYXC_BIT_INV_CODE = 2;
  localparam int PHYXC_BIT_SCR_DIS = 0;
  localparam logic PHYXC_RST_OVR = 1'h0;
  localparam logic PHYXC_RST_SCR_TEST = 1'h0;
  localparam logic PHYXC_RST_NRZI = 1'h1;
  localparam logic PHYXC_RST_INV_CODE = 1'h0;
  localparam logic PHYXC_RST_SCR_DIS = 1'h0;
  localparam logic [5:0] PHYXC_PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] PHYXC_OP_WRITE = 2'h1;
  localparam logic [1:0] PHYXC_OP_READ = 2'h2;
  localparam logic [4:0] PHYXC_HDR_LAST = 5'h0B;
  localparam logic [4:0] PHYXC_DATA_LAST = 5'h0F;
  localparam logic [1:0] PHYXC_SYNC_FILL = 2'h3;
endpackage
